// ==== irq_vec_cfg.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Function
`ifndef IRQ_VEC_CFG_SVH
`define IRQ_VEC_CFG_SVH
`define PRIO_HIGH_OFFSET 12'h0B7
`define PRIO_LOW_OFFSET 12'h0B8
`define INT_EN_OFFSET 12'h0A8
`define EXT_CTRL_OFFSET 12'h0C0
`define STATUS_OFFSET 12'h0C4
`define FLAGS_OFFSET 12'h0C8
// Printed offsets are word indices; the bus sees four times the index
`define PRIO_HIGH_ADDR (`PRIO_HIGH_OFFSET << 2)
`define PRIO_LOW_ADDR (`PRIO_LOW_OFFSET << 2)
`define INT_EN_ADDR (`INT_EN_OFFSET << 2)
`define EXT_CTRL_ADDR (`EXT_CTRL_OFFSET << 2)
`define STATUS_ADDR (`STATUS_OFFSET << 2)
`define FLAGS_ADDR (`FLAGS_OFFSET << 2)
`define REG_RESET 8'h00
`define SRC_COUNT 6
`define EN_GLOBAL_BIT 7
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define STATES_PER_CYCLE 6
`define EARLY_STATE 3'd1
`define LATE_STATE 3'd4
`endif

// ==== irq_vec_pkg.sv ====
// Purpose: Types for the interrupt vectoring block
// Assumes: Six sources in fixed polling order
// Notes: Index 0 is the highest in-level order
package irq_vec_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_call1 = 2'b01,
    st_call2 = 2'b10
  } call_state_t;
  typedef struct packed {
    logic retire_last;
    logic is_return_from_interrupt_instr;
    logic is_ret;
    logic wr_enable;
  } instr_info_t;
  typedef struct packed {
    logic valid;
    logic [15:0] pc;
    logic [15:0] vector;
  } call_req_t;
endpackage

// ==== irq_vectoring.sv ====
// Purpose: Four-level interrupt arbitration and vectoring
// Assumes: Machine cycle of six states derived from pclk
// Notes: Writes to the enable/priority map come from APB
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_vec_cfg.svh"
module irq_vectoring
  import irq_vec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic timer2_ext,
  input wire logic rx_done,
  input wire logic tx_done,
  input wire instr_info_t instr,
  input wire logic [15:0] cur_pc,
  output call_req_t call,
  output logic [2:0] state_ff,
  output logic cycle_tick
);
  logic [1:0] irq0_sync_ff, irq1_sync_ff;
  logic [7:0] prio_high_ff, prio_low_ff, int_en_ff, ext_ctrl_ff;
  logic [5:0] flag_ff, sample_ff;
  logic [3:0] in_prog_ff;
  logic irq0_prev_ff, irq1_prev_ff;
  call_state_t cs_ff;
  logic [2:0] src_ff;
  logic [5:0] live;
  logic [1:0] lvl [`SRC_COUNT];
  logic [1:0] top_lvl;
  logic top_any;
  logic win_any;
  logic [2:0] win_src;
  logic [1:0] win_lvl;
  logic wr_en, rd_en;
  logic [15:0] nxt_vec;

  // Machine cycle state counter; tick marks the last state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= 3'd0;
    else if (state_ff == 3'(`STATES_PER_CYCLE - 1))
      state_ff <= 3'd0;
    else
      state_ff <= state_ff + 3'd1;
  end
  assign cycle_tick = (state_ff == 3'(`STATES_PER_CYCLE - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq0_sync_ff <= 2'b11;
      irq1_sync_ff <= 2'b11;
    end
    else
    begin
      irq0_sync_ff <= {irq0_sync_ff[0], ext_irq0_pin};
      irq1_sync_ff <= {irq1_sync_ff[0], ext_irq1_pin};
    end
  end

  // APB slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pslverr = psel && penable &&
    !(paddr == `PRIO_HIGH_ADDR || paddr == `PRIO_LOW_ADDR ||
      paddr == `INT_EN_ADDR || paddr == `EXT_CTRL_ADDR ||
      paddr == `STATUS_ADDR || paddr == `FLAGS_ADDR);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prio_high_ff <= `REG_RESET;
      prio_low_ff <= `REG_RESET;
      int_en_ff <= `REG_RESET;
      ext_ctrl_ff <= `REG_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == `PRIO_HIGH_ADDR)
        prio_high_ff <= {2'b00, pwdata[5:0]};
      else if (paddr == `PRIO_LOW_ADDR)
        prio_low_ff <= {2'b00, pwdata[5:0]};
      else if (paddr == `INT_EN_ADDR)
        int_en_ff <= {pwdata[7], 1'b0, pwdata[5:0]};
      else if (paddr == `EXT_CTRL_ADDR)
        ext_ctrl_ff <= {6'h00, pwdata[1:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      if (paddr == `PRIO_HIGH_ADDR)
        prdata <= {24'h000000, prio_high_ff};
      else if (paddr == `PRIO_LOW_ADDR)
        prdata <= {24'h000000, prio_low_ff};
      else if (paddr == `INT_EN_ADDR)
        prdata <= {24'h000000, int_en_ff};
      else if (paddr == `EXT_CTRL_ADDR)
        prdata <= {24'h000000, ext_ctrl_ff};
      else if (paddr == `STATUS_ADDR)
        prdata <= {22'h0, cs_ff, in_prog_ff, 1'b0, src_ff};
      else if (paddr == `FLAGS_ADDR)
        prdata <= {26'h0, flag_ff};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Request flags, index order ext0,t0,ext1,t1,serial,t2
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_ff <= 6'h00;
      irq0_prev_ff <= 1'b1;
      irq1_prev_ff <= 1'b1;
    end
    else
    begin
      if (state_ff == `LATE_STATE)
      begin
        irq0_prev_ff <= irq0_sync_ff[1];
        irq1_prev_ff <= irq1_sync_ff[1];
        // Level mode follows the inverted pin; edge mode sets on fall
        flag_ff[0] <= ext_ctrl_ff[0] ? (flag_ff[0] ||
          (irq0_prev_ff && !irq0_sync_ff[1])) : !irq0_sync_ff[1];
        flag_ff[2] <= ext_ctrl_ff[1] ? (flag_ff[2] ||
          (irq1_prev_ff && !irq1_sync_ff[1])) : !irq1_sync_ff[1];
        flag_ff[1] <= flag_ff[1] || timer0_ovf;
        flag_ff[3] <= flag_ff[3] || timer1_ovf;
        flag_ff[4] <= rx_done || tx_done;
        flag_ff[5] <= timer2_ext || timer2_ovf;
      end
      else if (state_ff == `EARLY_STATE && timer2_ovf)
        flag_ff[5] <= 1'b1;
      // Hardware clear on vectoring; a set at the late phase is cleared again in the last state
      if (cs_ff == st_call1 && state_ff != `LATE_STATE)
      begin
        if (src_ff == 3'd1)
          flag_ff[1] <= 1'b0;
        if (src_ff == 3'd3)
          flag_ff[3] <= 1'b0;
        if (src_ff == 3'd0 && ext_ctrl_ff[0])
          flag_ff[0] <= 1'b0;
        if (src_ff == 3'd2 && ext_ctrl_ff[1])
          flag_ff[2] <= 1'b0;
      end
    end
  end

  // Snapshot at the sample point; timer 2 overflow joins early
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample_ff <= 6'h00;
    else if (state_ff == `LATE_STATE)
      sample_ff <= flag_ff;
    else if (state_ff == `EARLY_STATE && timer2_ovf)
      sample_ff[5] <= 1'b1;
  end

  assign live = sample_ff & int_en_ff[5:0] &
    {6{int_en_ff[`EN_GLOBAL_BIT]}};

  always_comb
  begin
    top_any = |in_prog_ff;
    top_lvl = 2'd0;
    for (int i = 0; i < 4; i++)
      if (in_prog_ff[i])
        top_lvl = 2'(i);
  end

  // Scan from lowest order upward so the first source wins a tie
  always_comb
  begin
    win_any = 1'b0;
    win_src = 3'd0;
    win_lvl = 2'd0;
    for (int i = `SRC_COUNT - 1; i >= 0; i--)
    begin
      lvl[i] = {prio_high_ff[i], prio_low_ff[i]};
      if (live[i] && (!win_any || lvl[i] >= win_lvl))
      begin
        win_any = 1'b1;
        win_src = 3'(i);
        win_lvl = lvl[i];
      end
    end
  end

  assign nxt_vec = `VEC_BASE + {10'h000, win_src, 3'b000};

  // Call sequencer: poll at cycle end, then two call cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_ff <= st_idle;
      src_ff <= 3'd0;
      in_prog_ff <= 4'h0;
      call <= '0;
    end
    else
    begin
      call.valid <= 1'b0;
      if (cycle_tick)
        case (cs_ff)
          st_idle:
          begin
            if (win_any && instr.retire_last
                && !(top_any && win_lvl <= top_lvl)
                // Blocking the deferring instruction's own poll is enough
                && !instr.is_return_from_interrupt_instr
                && !instr.wr_enable)
            begin
              cs_ff <= st_call1;
              src_ff <= win_src;
              call.valid <= 1'b1;
              call.pc <= cur_pc;
              call.vector <= nxt_vec;
              in_prog_ff[win_lvl] <= 1'b1;
            end
            else if (instr.retire_last && instr.is_return_from_interrupt_instr && top_any)
              in_prog_ff[top_lvl] <= 1'b0;
          end
          st_call1:
            cs_ff <= st_call2;
          st_call2:
            cs_ff <= st_idle;
          default:
            cs_ff <= st_idle;
        endcase
    end
  end
endmodule // irq_vectoring
`default_nettype wire

// ==== irq_vectoring_assertions.sv ====
// Purpose: Port checks for the vectoring block
// Assumes: One clock, six-state machine cycle
// Notes: Bound to every design instance by name
`timescale 1ns/1ps
`default_nettype none
module irq_vec_chk
  import irq_vec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire instr_info_t instr,
  input wire logic [15:0] cur_pc,
  input wire call_req_t call,
  input wire logic [2:0] state_ff,
  input wire logic cycle_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  tick_end_a: assert property (cycle_tick == (state_ff == 3'h5))
    else $error("tick");
  state_wrap_a: assert property (state_ff == 3'h5 |=> !state_ff)
    else $error("wrap");
  call_tick_a: assert property
    (call.valid |-> $past(cycle_tick && instr.retire_last)) else $error("call");
  call_gap_a: assert property (call.valid |=> !call.valid [*8])
    else $error("gap");
  vec_map_a: assert property
    (call.valid |-> call.vector[2:0] == 3'h3 && call.vector < 16'h30)
    else $error("vector");
  push_pc_a: assert property (call.valid |-> call.pc == $past(cur_pc))
    else $error("pc");
  defer_a: assert property
    (cycle_tick && (instr.is_return_from_interrupt_instr || instr.wr_enable) |=> !call.valid)
    else $error("defer");
  bus_err_a: assert property
    (psel && penable && !pwrite && paddr == 12'hFFC |->
      pslverr && pready && !prdata)
    else $error("bus");
  cover property (call.valid);
  cover property (cycle_tick && instr.is_return_from_interrupt_instr);
  cover property (pslverr);
endmodule // irq_vec_chk
bind irq_vectoring irq_vec_chk u_chk (.*);
`default_nettype wire

// ==== cpu_seq_model.sv ====
// Purpose: Instruction sequencer stand-in
// Assumes: Each instruction lasts len+1 machine cycles
// Notes: Jumps to the vector when a call is issued
`timescale 1ns/1ps
`default_nettype none
module cpu_seq_model
  import irq_vec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cycle_tick,
  input wire call_req_t call,
  input wire logic [1:0] len,
  input wire logic [2:0] kind,
  output var instr_info_t instr,
  output logic [15:0] cur_pc
);
  logic [1:0] cnt_ff;
  assign instr = {cnt_ff == len, kind};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 2'h0;
      cur_pc <= 16'h0100;
    end
    else if (call.valid)
      cur_pc <= call.vector;
    else if (cycle_tick)
    begin
      cnt_ff <= (cnt_ff == len) ? 2'h0 : cnt_ff + 2'h1;
      cur_pc <= cur_pc + 16'(cnt_ff == len);
    end
  end
endmodule // cpu_seq_model
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for irq_vectoring
// Assumes: Enable bits in polling order, bit 7 global
// Notes: Serial and timer 2 flags follow their inputs; a flags write is ignored
`timescale 1ns/1ps
`default_nettype none
`include "irq_vec_cfg.svh"
module tb;
  import irq_vec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] req;
  logic [1:0] len;
  logic [2:0] kind, state_ff;
  logic [15:0] cur_pc, ev;
  logic ext_irq0_pin, ext_irq1_pin, timer0_ovf, timer1_ovf;
  logic timer2_ovf, timer2_ext, rx_done, tx_done, cycle_tick;
  instr_info_t instr;
  call_req_t call;
  logic [15:0] q[$];
  int n_fail, num_checks, cyc;
  assign {timer2_ext, tx_done, timer2_ovf, rx_done, timer1_ovf} = req[7:3];
  assign ext_irq1_pin = ~req[2];
  assign timer0_ovf = req[1];
  assign ext_irq0_pin = ~req[0];
  irq_vectoring DUT (.*);
  cpu_seq_model seq (.*);
  always #2 pclk = ~pclk;
  task automatic fail(input logic [31:0] got, input logic [31:0] exp);
    n_fail++;
    $display("ERROR %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic summarize();
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    num_checks++;
    if ((rd & 32'h3F) !== exp) fail(rd, exp);
  endtask
  task automatic run(input logic [2:0] k);
    kind <= k;
    repeat (60) @(posedge pclk);
    kind <= 3'h0;
    @(posedge pclk);
  endtask
  task automatic wait_q();
    while (q.size() > 0) @(posedge pclk);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_fail++;
      summarize();
    end
    if (call.valid === 1'b1)
    begin
      ev = (q.size() > 0) ? q.pop_front() : 16'hFFFF;
      num_checks++;
      if (call.vector !== ev) fail(call.vector, ev);
    end
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {req, len, kind, n_fail, num_checks, cyc} = '0;
    void'($urandom(32'h80592B70));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`PRIO_HIGH_ADDR, 32'h0);
    apb(1'b1, `PRIO_HIGH_ADDR, 32'hFF);
    rdchk(`PRIO_HIGH_ADDR, 32'h3F);
    rdchk(12'hFFC, 32'h0);
    num_checks++;
    if (er !== 1'b1) fail({31'h0, er}, 32'h1);
    apb(1'b1, `INT_EN_ADDR, 32'hBF);
    for (int i = 0; i < 8; i++)
    begin
      len <= 2'($urandom_range(3));
      q.push_back(16'(3 + 8 * (i < 6 ? i : i - 2)));
      req <= 8'h1 << i;
      wait_q();
      req <= 8'h0;
      apb(1'b1, `FLAGS_ADDR, 32'h0);
      run(3'h4);
    end
    apb(1'b1, `INT_EN_ADDR, 32'h3F);
    req <= 8'h03;
    repeat (12) @(posedge pclk);
    req <= 8'h0;
    repeat (12) @(posedge pclk);
    q.push_back(16'h000B);
    apb(1'b1, `INT_EN_ADDR, 32'hBF);
    wait_q();
    run(3'h4);
    // Second source is queued only after ret, so an early call shows
    q.push_back(16'h000B);
    req <= 8'h0A;
    repeat (6) @(posedge pclk);
    req <= 8'h0;
    wait_q();
    run(3'h2);
    run(3'h1);
    q.push_back(16'h001B);
    run(3'h4);
    wait_q();
    run(3'h4);
    apb(1'b1, `PRIO_HIGH_ADDR, 32'h02);
    q.push_back(16'h0003);
    req <= 8'h01;
    wait_q();
    q.push_back(16'h000B);
    req <= 8'h02;
    repeat (6) @(posedge pclk);
    req <= 8'h0;
    wait_q();
    run(3'h4);
    run(3'h4);
    summarize();
  end
endmodule // tb
`default_nettype wire
